// ===== motor_pwm_timebase_pkg.sv
// package: register map, field layouts and timing constants of the pwm time base
package motor_pwm_timebase_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_PWM_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_REPETITION_COUNT = 8'h04;
    localparam logic [7:0] ADDR_CHOPPER_CTRL = 8'h08;
    localparam logic [7:0] ADDR_SYS_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_CMP_U = 8'h10;
    localparam logic [7:0] ADDR_CMP_V = 8'h14;
    localparam logic [7:0] ADDR_CMP_W = 8'h18;
    localparam logic [7:0] ADDR_PERIOD = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    // reset values
    localparam logic [7:0] PWM_CONTROL_RESET = 8'h00;
    localparam logic [7:0] REPETITION_RESET = 8'h00;
    localparam logic [7:0] CHOPPER_RESET = 8'h00;
    localparam logic [2:0] SYS_CTRL_RESET = 3'h0;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'h00FF;

    // system control bit positions
    localparam int SYS_CLK_EN_BIT = 0;
    localparam int SYS_IRQ_EN_BIT = 1;
    localparam int SYS_FMTC_LOW_BIT = 2;

    // status field positions
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_REP_LSB = 16;
    localparam int STAT_DIR_BIT = 24;

    // pwm_control layout, bit 7 down to bit 0
    typedef struct packed {
        logic resolution_mode_sel;
        logic phase_u_full_duty;
        logic phase_v_full_duty;
        logic phase_w_full_duty;
        logic counter_align_sel;
        logic [2:0] counter_prescale;
    } pwm_ctrl_type;

    // chopper control layout, bit 7 down to bit 0
    typedef struct packed {
        logic [2:0] reserved;
        logic [1:0] chopper_target_sel;
        logic [2:0] chopper_freq_sel;
    } chop_ctrl_type;

    // inverter gate drive, one bit per phase u, v, w (msb first)
    typedef struct packed {
        logic [2:0] high;
        logic [2:0] low;
    } gate_drive_type;

    // counting direction of the center-aligned counter
    typedef enum logic [0:0] {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } count_dir_type;

    // timing
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned CHOP_FREQ_HZ [8] = '{100_000, 200_000, 400_000, 500_000,
                                                 800_000, 1_000_000, 1_330_000, 2_000_000};
    localparam logic [2:0] PRESCALE_MAX_CODE = 3'h7;
    localparam logic [2:0] PRESCALE_MAX_DIV = 3'h7;

endpackage

// ===== motor_pwm_timebase.sv
// three-phase pwm time base with repetition counter, full-duty override and chopper
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module motor_pwm_timebase
    import motor_pwm_timebase_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // inverter side
    output logic [2:0] pwm_phase_o,
    output gate_drive_type gate_o,
    output logic chopper_o,
    // update events
    output logic update_event_o,
    output logic update_irq_o
);

    // chopper half period in system clocks, doubled when fmtc runs at the low rate
    function automatic logic [10:0] chop_half(input logic [2:0] sel, input logic low);
        int unsigned half;
        half = CLK_FREQ_HZ / (2 * CHOP_FREQ_HZ[sel]);
        if (low) begin
            half = half * 2;
        end
        return half[10:0];
    endfunction

    // prescaler division factor; the top code divides by seven as printed
    function automatic logic [2:0] prescale_div(input logic [2:0] code);
        logic [2:0] d;
        d = code + 3'h1;
        if (code == 3'h0) begin
            d = 3'h1;
        end else if (code == PRESCALE_MAX_CODE) begin
            d = PRESCALE_MAX_DIV;
        end
        return d;
    endfunction

    // compare value actually used, by resolution mode
    function automatic logic [15:0] eff_compare(input logic [15:0] cmp, input logic res);
        logic [15:0] c;
        c = {cmp[15:3], 3'h0};
        if (res) begin
            c = {cmp[15:8], 8'h00};
        end
        return c;
    endfunction

    // byte-lane merge for a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] dat,
                                            input logic [1:0] sel);
        logic [15:0] m;
        m = old;
        if (sel[0]) begin
            m[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            m[15:8] = dat[15:8];
        end
        return m;
    endfunction

    pwm_ctrl_type ctrl_pre_q;
    pwm_ctrl_type ctrl_act_q;
    chop_ctrl_type chop_ctrl_q;
    logic [7:0] rep_pre_q;
    logic [7:0] rep_act_q;
    logic [7:0] rep_cnt_q;
    logic [2:0] sys_q;
    logic [15:0] cmp_pre_q [3];
    logic [15:0] cmp_act_q [3];
    logic [15:0] period_q;
    logic [2:0] full_act_q;
    logic [2:0] presc_cnt_q;
    logic [15:0] cnt_q;
    count_dir_type dir_q;
    logic en_dly_q;
    logic [10:0] chop_cnt_q;
    logic chop_q;
    logic [2:0] pwm_q;
    gate_drive_type gate_q;
    logic upd_q;
    logic irq_q;
    logic wb_ack_q;
    logic [31:0] wb_dat_q;

    logic req;
    logic wr;
    logic sys_en;
    logic start;
    logic tick;
    logic at_top;
    logic boundary;
    logic upd;
    logic [2:0] div;
    logic [10:0] half;
    logic [31:0] rd_mux;

    // bus decode; a write lands on the edge that also samples ack
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & wb_ack_q;
    assign sys_en = sys_q[SYS_CLK_EN_BIT];
    assign start = sys_en & ~en_dly_q;

    // prescaler tick and period boundary detection
    assign div = prescale_div(ctrl_act_q.counter_prescale);
    assign tick = sys_en & (presc_cnt_q == (div - 3'h1));
    // a period written below the running count still ends the period at once
    assign at_top = (cnt_q >= period_q);
    always_comb begin
        boundary = at_top;
        if (ctrl_act_q.counter_align_sel) begin
            case (dir_q)
                DIR_UP: boundary = at_top;
                DIR_DOWN: boundary = (cnt_q == 16'h0000);
                default: boundary = 1'b0;
            endcase
        end
    end

    // update: forced at enable, else when repetition counter expires
    assign upd = start | (tick & boundary & (rep_cnt_q == 8'h00));
    assign half = chop_half(chop_ctrl_q.chopper_freq_sel, sys_q[SYS_FMTC_LOW_BIT]);

    // wishbone ack, one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_q <= 1'b0;
        end else begin
            wb_ack_q <= req & ~wb_ack_q;
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            ADDR_PWM_CONTROL: rd_mux[7:0] = ctrl_pre_q;
            ADDR_REPETITION_COUNT: rd_mux[7:0] = rep_pre_q;
            ADDR_CHOPPER_CTRL: rd_mux[4:0] = chop_ctrl_q[4:0];
            ADDR_SYS_CTRL: rd_mux[2:0] = sys_q;
            ADDR_CMP_U: rd_mux[15:0] = cmp_pre_q[0];
            ADDR_CMP_V: rd_mux[15:0] = cmp_pre_q[1];
            ADDR_CMP_W: rd_mux[15:0] = cmp_pre_q[2];
            ADDR_PERIOD: rd_mux[15:0] = period_q;
            ADDR_STATUS: begin
                rd_mux[STAT_CNT_LSB +: 16] = cnt_q;
                rd_mux[STAT_REP_LSB +: 8] = rep_cnt_q;
                rd_mux[STAT_DIR_BIT] = dir_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured as ack rises
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_dat_q <= 32'h0000_0000;
        end else if (req & ~wb_ack_q) begin
            wb_dat_q <= rd_mux;
        end
    end

    // control preload; override bits self-clear at update, a same-cycle write wins
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_pre_q <= PWM_CONTROL_RESET;
        end else if (wr && wb_adr_i == ADDR_PWM_CONTROL && wb_sel_i[0]) begin
            ctrl_pre_q <= wb_dat_i[7:0];
        end else if (upd) begin
            ctrl_pre_q.phase_u_full_duty <= 1'b0;
            ctrl_pre_q.phase_v_full_duty <= 1'b0;
            ctrl_pre_q.phase_w_full_duty <= 1'b0;
        end
    end

    // other software registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rep_pre_q <= REPETITION_RESET;
            chop_ctrl_q <= CHOPPER_RESET;
            sys_q <= SYS_CTRL_RESET;
            period_q <= PERIOD_RESET;
            for (int i = 0; i < 3; i++) begin
                cmp_pre_q[i] <= CMP_RESET;
            end
        end else if (wr) begin
            case (wb_adr_i)
                ADDR_REPETITION_COUNT: if (wb_sel_i[0]) rep_pre_q <= wb_dat_i[7:0];
                ADDR_CHOPPER_CTRL: if (wb_sel_i[0]) chop_ctrl_q <= {3'h0, wb_dat_i[4:0]};
                ADDR_SYS_CTRL: if (wb_sel_i[0]) sys_q <= wb_dat_i[2:0];
                ADDR_CMP_U: cmp_pre_q[0] <= merge16(cmp_pre_q[0], wb_dat_i[15:0], wb_sel_i[1:0]);
                ADDR_CMP_V: cmp_pre_q[1] <= merge16(cmp_pre_q[1], wb_dat_i[15:0], wb_sel_i[1:0]);
                ADDR_CMP_W: cmp_pre_q[2] <= merge16(cmp_pre_q[2], wb_dat_i[15:0], wb_sel_i[1:0]);
                ADDR_PERIOD: period_q <= merge16(period_q, wb_dat_i[15:0], wb_sel_i[1:0]);
                default: sys_q <= sys_q;
            endcase
        end
    end

    // active copies; while stopped the mode follows preload, else only at update
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_act_q <= PWM_CONTROL_RESET;
            rep_act_q <= REPETITION_RESET;
            full_act_q <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                cmp_act_q[i] <= CMP_RESET;
            end
        end else if (upd) begin
            ctrl_act_q <= ctrl_pre_q;
            rep_act_q <= rep_pre_q;
            full_act_q <= {ctrl_pre_q.phase_u_full_duty, ctrl_pre_q.phase_v_full_duty,
                           ctrl_pre_q.phase_w_full_duty};
            for (int i = 0; i < 3; i++) begin
                cmp_act_q[i] <= cmp_pre_q[i];
            end
        end else if (!sys_en) begin
            ctrl_act_q <= ctrl_pre_q;
            full_act_q <= 3'h0;
        end
    end

    // enable edge detect and repetition down-counter
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_dly_q <= 1'b0;
            rep_cnt_q <= 8'h00;
        end else begin
            en_dly_q <= sys_en;
            if (upd) begin
                rep_cnt_q <= rep_pre_q;
            end else if (tick && boundary) begin
                rep_cnt_q <= rep_cnt_q - 8'h01;
            end
        end
    end

    // prescaler
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            presc_cnt_q <= 3'h0;
        end else if (!sys_en || tick || presc_cnt_q >= div) begin
            presc_cnt_q <= 3'h0;
        end else begin
            presc_cnt_q <= presc_cnt_q + 3'h1;
        end
    end

    // pwm counter; center mode holds one tick at each turn so halves are equal
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 16'h0000;
            dir_q <= DIR_UP;
        end else if (!sys_en) begin
            cnt_q <= 16'h0000;
            dir_q <= DIR_UP;
        end else if (start) begin
            // first period after enable is a full one, counted from zero
            cnt_q <= 16'h0000;
            dir_q <= DIR_UP;
        end else if (tick) begin
            if (!ctrl_act_q.counter_align_sel) begin
                dir_q <= DIR_UP;
                cnt_q <= at_top ? 16'h0000 : cnt_q + 16'h0001;
            end else begin
                case (dir_q)
                    DIR_UP: begin
                        if (at_top) begin
                            dir_q <= DIR_DOWN;
                        end else begin
                            cnt_q <= cnt_q + 16'h0001;
                        end
                    end
                    DIR_DOWN: begin
                        if (cnt_q == 16'h0000) begin
                            dir_q <= DIR_UP;
                        end else begin
                            cnt_q <= cnt_q - 16'h0001;
                        end
                    end
                    default: dir_q <= DIR_UP;
                endcase
            end
        end
    end

    // chopper: toggles every half period, so the duty stays at one half
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chop_cnt_q <= 11'h000;
            chop_q <= 1'b0;
        end else if (!sys_en) begin
            chop_cnt_q <= 11'h000;
            chop_q <= 1'b0;
        end else if (chop_cnt_q >= half - 11'h001) begin
            chop_cnt_q <= 11'h000;
            chop_q <= ~chop_q;
        end else begin
            chop_cnt_q <= chop_cnt_q + 11'h001;
        end
    end

    // phase outputs and gate drive; extension bit forces the phase high only while resolution_mode_sel is clear
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwm_q <= 3'h0;
            gate_q <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                logic ext;
                logic on;
                ext = full_act_q[2 - i];
                if (!ctrl_act_q.resolution_mode_sel) begin
                    ext = ext | cmp_act_q[i][15];
                end
                on = sys_en & (ext | (cnt_q < eff_compare(cmp_act_q[i],
                                                          ctrl_act_q.resolution_mode_sel)));
                pwm_q[2 - i] <= on;
                gate_q.high[2 - i] <= on & (~chop_ctrl_q.chopper_target_sel[1] | chop_q);
                gate_q.low[2 - i] <= sys_en & ~on &
                                     (~chop_ctrl_q.chopper_target_sel[0] | chop_q);
            end
        end
    end

    // update pulse and gated interrupt; the transfer itself never waits for the enable
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            upd_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            upd_q <= upd;
            irq_q <= upd & sys_q[SYS_IRQ_EN_BIT];
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;
    assign pwm_phase_o = pwm_q;
    assign gate_o = gate_q;
    assign chopper_o = chop_q;
    assign update_event_o = upd_q;
    assign update_irq_o = irq_q;

    // checks
    AST_CHOP_HALF: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (sys_en && $past(sys_en) && chop_q != $past(chop_q) && $past(half) == $past(half, 2))
        |-> $past(chop_cnt_q) == $past(half) - 11'h001)
        else $error("chopper toggled off its half period");
    AST_FULL_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (upd && !(wr && wb_adr_i == ADDR_PWM_CONTROL)) |=>
        !(ctrl_pre_q.phase_u_full_duty | ctrl_pre_q.phase_v_full_duty | ctrl_pre_q.phase_w_full_duty))
        else $error("override bit not cleared after update");
    AST_FULL_XFER: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        upd |=> full_act_q == {$past(ctrl_pre_q.phase_u_full_duty),
                               $past(ctrl_pre_q.phase_v_full_duty), $past(ctrl_pre_q.phase_w_full_duty)})
        else $error("override bits not transferred at update");
    AST_FULL_DUTY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (sys_en && full_act_q[2]) |=> pwm_phase_o[2])
        else $error("phase u not at full duty under override");
    AST_REP_RELOAD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        upd |=> (rep_cnt_q == rep_act_q) && update_event_o)
        else $error("repetition counter not reloaded at update");
    AST_REP_STEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (tick && boundary && !upd) |=> rep_cnt_q == $past(rep_cnt_q) - 8'h01)
        else $error("repetition counter did not step at boundary");
    AST_IRQ_GATE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        update_irq_o |-> $past(sys_q[SYS_IRQ_EN_BIT]) && update_event_o)
        else $error("update interrupt while disabled");
    AST_START_UPD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(sys_en) |-> upd ##1 (rep_act_q == $past(rep_pre_q)))
        else $error("enable did not force update");
    AST_EDGE_WRAP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (tick && !ctrl_act_q.counter_align_sel && at_top) |=> cnt_q == 16'h0000)
        else $error("edge counter did not wrap at period");
    AST_CENTER_TURN: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (tick && ctrl_act_q.counter_align_sel && dir_q == DIR_UP && at_top) |=> dir_q == DIR_DOWN)
        else $error("center counter did not turn at period");
    AST_ACT_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (sys_en && !upd) |=> $stable(ctrl_act_q) && $stable(rep_act_q))
        else $error("active copy changed outside update");

endmodule

`default_nettype wire

// ===== motor_inverter_model.sv
// behavioural three-leg inverter bridge driven by the gate outputs
`timescale 1ns/10ps
`default_nettype none

module motor_inverter_model
    import motor_pwm_timebase_pkg::*;
(
    // clock
    input wire logic clk_i,
    // gate drive from the time base
    input wire gate_drive_type gate_i,
    // bridge state
    output logic [2:0] node_o,
    output logic shoot_o
);
    initial node_o = 3'h0;
    initial shoot_o = 1'b0;

    // a leg with both switches off floats: show the inverse of its last level
    always @(posedge clk_i) begin
        for (int k = 0; k < 3; k++) begin
            if (gate_i.high[k])
                node_o[k] <= 1'b1;
            else if (gate_i.low[k])
                node_o[k] <= 1'b0;
            else
                node_o[k] <= ~node_o[k];
        end
        // both switches of one leg on would short the supply
        if (|(gate_i.high & gate_i.low))
            shoot_o <= 1'b1;
    end
endmodule

`default_nettype wire

// ===== motor_pwm_timebase_tb_top.sv
// self-checking bench for the pwm time base
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module motor_pwm_timebase_tb_top
    import motor_pwm_timebase_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, chop, upd, irq, shoot;
    logic [2:0] phase, node;
    gate_drive_type gate;
    int checked = 0;
    int miscompares = 0;
    int cycles = 0;
    int len, hu, gu, gl, irqs, hi, lo, dv, t0, seen;
    logic [31:0] q;
    logic [7:0] dctl [4] = '{8'h00, 8'h00, 8'h80, 8'h80};
    logic [15:0] dcmp [4] = '{16'h0008, 16'h8000, 16'h0008, 16'h0100};
    int dexp [4] = '{8, 16, 0, 16};

    always #5 clk = ~clk;

    motor_pwm_timebase i_motor_pwm_timebase (
        .clk_sys_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pwm_phase_o(phase), .gate_o(gate), .chopper_o(chop), .update_event_o(upd),
        .update_irq_o(irq));

    motor_inverter_model i_motor_inverter_model (
        .clk_i(clk), .gate_i(gate), .node_o(node), .shoot_o(shoot));

    task automatic final_report();
        $display("counts: checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, far above the roughly 12000 cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            final_report();
        end
    end

    // one classic wishbone cycle; held until ack is sampled, then released
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic wait_upd();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (upd !== 1'b1 && n < 2000);
        `CHK("update pulse", 1'b1, upd)
    endtask

    // counts samples from one update pulse to the next
    task automatic span(input int p);
        len = 0;
        hu = 0;
        gu = 0;
        gl = 0;
        irqs = 0;
        do begin
            @(posedge clk);
            len++;
            hu += int'(phase[p] === 1'b1);
            gu += int'(gate.high[2] === 1'b1);
            gl += int'(gate.low[2] === 1'b1);
            irqs += int'(irq === 1'b1);
        end while (upd !== 1'b1 && len < 5000);
    endtask

    task automatic run_while(input logic v, output int n);
        n = 0;
        while (chop === v && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask

    // samples down-count direction over about 30 cycles
    task automatic dir_seen(output int s);
        s = 0;
        repeat (10) begin
            wb(1'b0, ADDR_STATUS, 32'h0);
            s |= int'(q[STAT_DIR_BIT]);
        end
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, unmapped read, preload readback
        wb(1'b0, ADDR_PWM_CONTROL, 32'h0);
        `CHK("pwm_control reset", 32'h0, q)
        wb(1'b0, ADDR_REPETITION_COUNT, 32'h0);
        `CHK("repetition_count reset", 32'h0, q)
        wb(1'b0, 8'h3C, 32'h0);
        `CHK("unmapped read", 32'h0, q)
        wr(ADDR_PWM_CONTROL, 32'h0B);
        wb(1'b0, ADDR_PWM_CONTROL, 32'h0);
        `CHK("pwm_control preload", 32'h0B, q)
        $display("test registers done");
        // edge mode pacing, enable start, repeat change while running
        wr(ADDR_PWM_CONTROL, 32'h00);
        wr(ADDR_PERIOD, 32'h9);
        wr(ADDR_REPETITION_COUNT, 32'h2);
        wr(ADDR_SYS_CTRL, 32'h3);
        wait_upd();
        span(2);
        `CHK("edge interval", 30, len)
        `CHK("irq per update", 1, irqs)
        t0 = cycles;
        wr(ADDR_REPETITION_COUNT, 32'h4);
        wait_upd();
        `CHK("interval during write", 30, cycles - t0)
        span(2);
        `CHK("new repeat interval", 50, len)
        wr(ADDR_SYS_CTRL, 32'h1);
        wait_upd();
        span(2);
        `CHK("irq masked", 0, irqs)
        `CHK("masked interval", 50, len)
        $display("test repetition done");
        // every prescale code, short period so the run stays brief
        wr(ADDR_PERIOD, 32'h3);
        wr(ADDR_REPETITION_COUNT, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_PWM_CONTROL, 32'(c));
            wait_upd();
            wait_upd();
            span(2);
            dv = (c == 0) ? 1 : (c == 7) ? 7 : c + 1;
            `CHK("prescaled interval", 4 * dv, len)
        end
        $display("test prescale done");
        // center mode counts half periods and turns down
        wr(ADDR_PERIOD, 32'h9);
        wr(ADDR_REPETITION_COUNT, 32'h1);
        wr(ADDR_PWM_CONTROL, 32'h08);
        wait_upd();
        wait_upd();
        span(2);
        `CHK("center interval", 20, len)
        dir_seen(seen);
        `CHK("center counts down", 1, seen)
        // compare resolution and extension bit
        wr(ADDR_PERIOD, 32'hF);
        wr(ADDR_REPETITION_COUNT, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_PWM_CONTROL, {24'h0, dctl[i]});
            wr(ADDR_CMP_U, {16'h0, dcmp[i]});
            wait_upd();
            wait_upd();
            span(2);
            `CHK("phase u duty", dexp[i], hu)
        end
        dir_seen(seen);
        `CHK("edge never counts down", 0, seen)
        $display("test compare done");
        // full-duty override on each phase, then release
        wr(ADDR_PERIOD, 32'h63);
        wr(ADDR_CMP_U, 32'h0);
        wr(ADDR_PWM_CONTROL, 32'h00);
        for (int p = 0; p < 3; p++) begin
            wr(ADDR_PWM_CONTROL, 32'h40 >> p);
            wait_upd();
            span(2 - p);
            `CHK("forced duty", 1'b1, hu >= len - 2)
            wb(1'b0, ADDR_PWM_CONTROL, 32'h0);
            `CHK("override self clear", 32'h0, q)
            span(2 - p);
            `CHK("duty after release", 1'b1, hu <= 2)
        end
        $display("test override done");
        // chopper targets: high gate while forced, low gate after release
        for (int t = 0; t < 4; t++) begin
            wr(ADDR_CHOPPER_CTRL, {27'h0, 2'(t), 3'h7});
            wr(ADDR_PWM_CONTROL, 32'h40);
            wait_upd();
            span(2);
            `CHK("high gate chopped", t[1], gu < len - 10)
            span(2);
            `CHK("low gate chopped", t[0], gl < len - 10)
        end
        `CHK("bridge shoot-through", 1'b0, shoot)
        // every chopper rate, then the slow peripheral clock case
        for (int f = 0; f < 9; f++) begin
            wr(ADDR_SYS_CTRL, (f == 8) ? 32'h5 : 32'h1);
            wr(ADDR_CHOPPER_CTRL, 32'(f % 8));
            run_while(1'b1, hi);
            run_while(1'b0, lo);
            run_while(1'b1, hi);
            run_while(1'b0, lo);
            dv = int'(CLK_FREQ_HZ / (2 * CHOP_FREQ_HZ[f % 8])) * ((f == 8) ? 2 : 1);
            `CHK("chopper half period", dv, hi)
            `CHK("chopper duty", hi, lo)
        end
        $display("test chopper done");
        final_report();
    end
endmodule

`default_nettype wire
